//--- verilog/fbo_pkg.sv
// Shared constants and carriers of the flash map and boot overlay control.
// Assumes a single 25 MHz clock and a 16-bit control register bus.
package fbo_pkg;

  // ----------------------------------------------------------------------
  // Bus and register layout
  // ----------------------------------------------------------------------
  localparam int unsigned  SFR_AW          = 11;
  localparam logic [10:0]  AUX_SFR_ADDR    = 11'h4a8;   // Control register address
  localparam logic [7:0]   AUX_RESET       = 8'h00;
  localparam int unsigned  AUX_BOOT_BIT    = 7;
  localparam int unsigned  AUX_VALID_BIT   = 6;
  localparam logic [7:0]   UPPER_READ      = 8'h00;     // Undefined upper byte, shown as zero
  localparam logic [7:0]   STATUS_BLANK    = 8'h00;

  // ----------------------------------------------------------------------
  // Memory map
  // ----------------------------------------------------------------------
  localparam logic [15:0]  BOOT_ROM_BASE   = 16'hf800;
  localparam logic [15:0]  SMALL_BLK_TOP   = 16'h3fff;
  localparam logic [3:0]   INT_SPACE_HI    = 4'h0;      // Upper nibble of the internal 64 KB

  // ----------------------------------------------------------------------
  // Timing of the programming-voltage generator
  // ----------------------------------------------------------------------
  localparam int unsigned  CLK_PERIOD_NS   = 40;
  localparam int unsigned  VPP_READY_NS    = 5000;
  localparam int unsigned  VPP_READY_CYC   = (VPP_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned  VPP_CNT_W       = 8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {FBO_OP_READ, FBO_OP_PROG, FBO_OP_CHIP_ERASE, FBO_OP_BLK_ERASE}
    fbo_op_e;
  typedef enum logic [1:0] {FBO_TGT_FLASH, FBO_TGT_BOOT, FBO_TGT_EXT} fbo_target_e;

  typedef struct packed {
    fbo_op_e     op;
    logic [15:0] addr;
    logic [7:0]  data;
  } fbo_flash_cmd_s;

  typedef struct packed {
    logic        strobe;
    fbo_op_e     op;
    logic [2:0]  block;
    logic [15:0] addr;
    logic [7:0]  data;
  } fbo_flash_req_s;

  typedef struct packed {
    fbo_target_e target;
    logic [19:0] addr;
  } fbo_fetch_s;

endpackage

//--- verilog/fbo_vpp_gen.sv
// Start-up timer of the on-chip programming-voltage generator.
// Assumes enable and supply strap come from logic on the same clock.
`timescale 1ns/100ps
module fbo_vpp_gen (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  input  wire logic vpp_tied_logic_i,
  output logic      ready_o
);
  import fbo_pkg::*;

  localparam logic [VPP_CNT_W-1:0] READY_CNT = VPP_CNT_W'(VPP_READY_CYC);

  logic [VPP_CNT_W-1:0] count;
  wire                  pump_on = enable_i & vpp_tied_logic_i;
  wire                  ext_ok  = enable_i & ~vpp_tied_logic_i;
  wire                  done    = (count == READY_CNT);

  // Count settling time while the pump runs; an external supply is ready at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count   <= '0;
      ready_o <= 1'b0;
    end else begin
      count   <= pump_on ? (done ? count : count + 1'b1) : '0;
      ready_o <= ext_ok | (pump_on & done);
    end
  end

endmodule // fbo_vpp_gen

//--- verilog/fbo_ctrl.sv
// Program-memory map, boot ROM overlay and flash access control.
// Assumes a core on the same clock driving the control register bus and
// fetch port; strap pins and the supply strap arrive asynchronously.
`timescale 1ns/100ps
module fbo_ctrl (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // Control register bus
  input  wire logic [fbo_pkg::SFR_AW-1:0] sfr_addr_i,
  input  wire logic                    sfr_wr_i,
  input  wire logic                    sfr_rd_i,
  input  wire logic                    sfr_wide_i,
  input  wire logic [15:0]             sfr_wdata_i,
  output logic      [15:0]             sfr_rdata_o,
  // Pins
  input  wire logic                    program_store_strobe_n_i,
  input  wire logic                    addr_latch_i,
  input  wire logic                    external_access_select_i,
  input  wire logic                    vpp_tied_logic_i,
  // Flash status byte
  input  wire logic [7:0]              flash_status_i,
  // Fetch port
  input  wire logic                    fetch_req_i,
  input  wire logic [19:0]             fetch_addr_i,
  output fbo_pkg::fbo_fetch_s          fetch_o,
  // Flash access port
  input  wire logic                    cmd_valid_i,
  input  wire fbo_pkg::fbo_flash_cmd_s cmd_i,
  output fbo_pkg::fbo_flash_req_s      flash_req_o,
  // Status outputs
  output logic                         boot_rom_enable_o,
  output logic                         boot_vector_sel_o
);
  import fbo_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Block number of a flash byte address
  function automatic logic [2:0] block_of(input logic [15:0] a);
    logic [2:0] b;
    b = 3'h0;
    if (a <= SMALL_BLK_TOP) b = {2'b00, a[13]};
    else                    b = 3'(a[15:14]) + 3'h1;
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  wire        strobe_n_s = pin_s2[0];
  wire        latch_s    = pin_s2[1];
  wire        ext_sel_s  = pin_s2[2];
  wire        tied_s     = pin_s2[3];

  // Two flops on each asynchronous pin
  always_ff @(posedge clk_i) begin
    pin_s1 <= {vpp_tied_logic_i, external_access_select_i, addr_latch_i,
               program_store_strobe_n_i};
    pin_s2 <= pin_s1;
  end

  // ----------------------------------------------------------------------
  // Reset-time boot decision
  // ----------------------------------------------------------------------
  logic in_reset;
  logic boot_en;
  logic prog_voltage_valid;
  wire  status_set = (flash_status_i != STATUS_BLANK);
  wire  strap_set  = ~strobe_n_s & latch_s & ext_sel_s;
  wire  boot_at_rst = status_set | strap_set;

  // Register write decode; only the boot bit of the low byte is ever stored
  wire  aux_hit   = (sfr_addr_i == AUX_SFR_ADDR);
  wire  aux_write = sfr_wr_i & aux_hit;
  wire  next_boot_en = in_reset  ? boot_at_rst :
                       aux_write ? sfr_wdata_i[AUX_BOOT_BIT] : boot_en;

  // Boot enable: caught on the first edge after reset release, then software owned
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_reset          <= 1'b1;
      boot_en           <= AUX_RESET[AUX_BOOT_BIT];
      boot_vector_sel_o <= 1'b0;
    end else begin
      in_reset <= 1'b0;
      boot_en  <= next_boot_en;
      if (in_reset) boot_vector_sel_o <= boot_at_rst;
    end
  end

  // ----------------------------------------------------------------------
  // Programming-voltage generator
  // ----------------------------------------------------------------------
  fbo_vpp_gen fbo_vpp_gen_inst (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .enable_i         (boot_en),
    .vpp_tied_logic_i (tied_s),
    .ready_o          (prog_voltage_valid)
  );

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  // Valid bit is never stored from the bus, unimplemented bits read zero
  wire [7:0]  aux_view  = {boot_en, prog_voltage_valid, 6'h00};
  wire [15:0] next_rdat = (sfr_rd_i & aux_hit) ?
                          {(sfr_wide_i ? UPPER_READ : 8'h00), aux_view} : 16'h0000;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o       <= 16'h0000;
      boot_rom_enable_o <= 1'b0;
    end else begin
      sfr_rdata_o       <= next_rdat;
      boot_rom_enable_o <= next_boot_en;
    end
  end

  // ----------------------------------------------------------------------
  // Fetch decode
  // ----------------------------------------------------------------------
  wire in_int   = (fetch_addr_i[19:16] == INT_SPACE_HI);
  wire in_top   = (fetch_addr_i[15:0] >= BOOT_ROM_BASE);
  fbo_target_e next_tgt;
  assign next_tgt = (!ext_sel_s || !in_int) ? FBO_TGT_EXT :
                    (boot_en && in_top) ? FBO_TGT_BOOT :
                    FBO_TGT_FLASH;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fetch_o <= '{target: FBO_TGT_FLASH, addr: 20'h00000};
    end else if (fetch_req_i) begin
      fetch_o <= '{target: next_tgt, addr: fetch_addr_i};
    end
  end

  // ----------------------------------------------------------------------
  // Flash byte access and erase requests
  // ----------------------------------------------------------------------
  fbo_flash_req_s next_req;
  assign next_req = '{strobe: cmd_valid_i, op: cmd_i.op, block: block_of(cmd_i.addr),
                      addr: cmd_i.addr, data: cmd_i.data};

  // One-cycle strobe per byte or erase command
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      flash_req_o <= '{strobe: 1'b0, op: FBO_OP_READ, block: 3'h0, addr: 16'h0000,
                       data: 8'h00};
    end else begin
      flash_req_o <= next_req;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_boot_overlay;
    @(posedge clk_i) disable iff (!rst_n_i)
      fetch_req_i && ext_sel_s && in_int && in_top && boot_en |=> fetch_o.target == FBO_TGT_BOOT;
  endproperty
  a_boot_overlay: assert property (p_boot_overlay) else $error("top fetch missed boot ROM");

  property p_flash_top;
    @(posedge clk_i) disable iff (!rst_n_i)
      fetch_req_i && ext_sel_s && in_int && !boot_en |=> fetch_o.target == FBO_TGT_FLASH;
  endproperty
  a_flash_top: assert property (p_flash_top) else $error("fetch missed flash");

  property p_external;
    @(posedge clk_i) disable iff (!rst_n_i)
      fetch_req_i && !ext_sel_s |=> fetch_o.target == FBO_TGT_EXT
                                    && fetch_o.addr == $past(fetch_addr_i);
  endproperty
  a_external: assert property (p_external) else $error("external fetch wrong");

  property p_low_byte_write;
    @(posedge clk_i) disable iff (!rst_n_i)
      aux_write && !in_reset ##1 !sfr_wr_i ##1 sfr_rd_i && aux_hit && !sfr_wr_i
        |=> sfr_rdata_o[AUX_BOOT_BIT] == $past(sfr_wdata_i[AUX_BOOT_BIT], 3)
            && sfr_rdata_o[15:8] == UPPER_READ;
  endproperty
  a_low_byte_write: assert property (p_low_byte_write) else $error("control write lost");

  property p_valid_readonly;
    @(posedge clk_i) disable iff (!rst_n_i)
      sfr_rd_i && aux_hit |=> sfr_rdata_o[AUX_VALID_BIT] == $past(prog_voltage_valid)
                               && sfr_rdata_o[5:0] == 6'h00;
  endproperty
  a_valid_readonly: assert property (p_valid_readonly) else $error("valid bit not status");

  property p_valid_needs_boot;
    @(posedge clk_i) disable iff (!rst_n_i)
      prog_voltage_valid |-> $past(boot_en);
  endproperty
  a_valid_needs_boot: assert property (p_valid_needs_boot) else $error("valid without boot");

  property p_valid_delay;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(boot_en) && tied_s |-> ##[1:130] (prog_voltage_valid || !boot_en || !tied_s);
  endproperty
  a_valid_delay: assert property (p_valid_delay) else $error("voltage never valid");

  property p_reset_boot;
    @(posedge clk_i) disable iff (!rst_n_i)
      in_reset |=> boot_en == $past(boot_at_rst) && boot_vector_sel_o == $past(boot_at_rst);
  endproperty
  a_reset_boot: assert property (p_reset_boot) else $error("reset boot choice wrong");

  property p_block_erase;
    @(posedge clk_i) disable iff (!rst_n_i)
      cmd_valid_i && cmd_i.op == FBO_OP_BLK_ERASE
        |=> flash_req_o.strobe && flash_req_o.block == block_of($past(cmd_i.addr));
  endproperty
  a_block_erase: assert property (p_block_erase) else $error("block erase wrong");

  property p_block_range;
    @(posedge clk_i) disable iff (!rst_n_i)
      flash_req_o.strobe |-> flash_req_o.block <= 3'h4;
  endproperty
  a_block_range: assert property (p_block_range) else $error("block out of range");

  c_boot_fetch:  cover property (@(posedge clk_i) fetch_o.target == FBO_TGT_BOOT);
  c_valid_rise:  cover property (@(posedge clk_i) $rose(prog_voltage_valid));
  c_strap_boot:  cover property (@(posedge clk_i) in_reset && strap_set && !status_set);
  c_chip_erase:  cover property (@(posedge clk_i) cmd_valid_i && cmd_i.op == FBO_OP_CHIP_ERASE);

endmodule // fbo_ctrl

//--- verification/fbo_core_model.sv
// Processor core model: drives the register bus, the fetch port and flash commands.
// Assumes its tasks are called from one bench process on the same clock.
`timescale 1ns/100ps
module fbo_core_model (
  input  wire logic                    clk_i,
  output logic [fbo_pkg::SFR_AW-1:0]   sfr_addr_o,
  output logic                         sfr_wr_o,
  output logic                         sfr_rd_o,
  output logic                         sfr_wide_o,
  output logic [15:0]                  sfr_wdata_o,
  output logic                         fetch_req_o,
  output logic [19:0]                  fetch_addr_o,
  output logic                         cmd_valid_o,
  output fbo_pkg::fbo_flash_cmd_s      cmd_o
);
  import fbo_pkg::*;
  // ----------------------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------------------
  initial begin
    {sfr_addr_o, sfr_wr_o, sfr_rd_o, sfr_wide_o, sfr_wdata_o} = '0;
    {fetch_req_o, fetch_addr_o, cmd_valid_o, cmd_o} = '0;
  end
  // One register access held over its taking edge; released address and data show inverse, strobes go low
  task automatic sfr_acc(input logic wr, input logic wide, input logic [10:0] a,
                         input logic [15:0] d);
    @(posedge clk_i); #2;
    sfr_addr_o = a;
    sfr_wdata_o = d & 16'hffc0;
    sfr_wide_o = wide;
    sfr_wr_o = wr;
    sfr_rd_o = ~wr;
    @(posedge clk_i); #2;
    {sfr_wr_o, sfr_rd_o} = 2'b00;
    sfr_addr_o = ~a;
    sfr_wdata_o = ~sfr_wdata_o;
  endtask
  // One code fetch
  task automatic fetch(input logic [19:0] a);
    @(posedge clk_i); #2;
    fetch_req_o = 1'b1;
    fetch_addr_o = a;
    @(posedge clk_i); #2;
    fetch_req_o = 1'b0;
    fetch_addr_o = ~a;
  endtask
  // One byte-wide flash command
  task automatic cmd(input fbo_op_e op, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i); #2;
    cmd_valid_o = 1'b1;
    cmd_o = '{op: op, addr: a, data: d};
    @(posedge clk_i); #2;
    cmd_valid_o = 1'b0;
    cmd_o = ~cmd_o;
  endtask
endmodule // fbo_core_model

//--- verification/flash_boot_overlay_control_bench.sv
// Self-checking bench of the flash map and boot overlay control.
// Assumes the core model drives the buses; strap pins come from the bench.
`timescale 1ns/100ps
module flash_boot_overlay_control_bench;
  import fbo_pkg::*;
  logic clk_i, rst_n_i, strobe_n, latch, ext_sel, vpp_tied;
  logic [7:0] status;
  logic [10:0] sfr_addr;
  logic sfr_wr, sfr_rd, sfr_wide, fetch_req, cmd_valid, boot_en, vec_sel;
  logic [15:0] sfr_wdata, sfr_rdata;
  logic [19:0] fetch_addr;
  fbo_flash_cmd_s cmd;
  fbo_flash_req_s freq;
  fbo_fetch_s fetch;
  logic [31:0] exp_q[$];
  int err_count, total_checks, cyc;
  int seed = 32'h3eb0;
  logic [15:0] addrs[7] = '{16'h1fff, 16'h2000, 16'h3fff, 16'h4000, 16'hbfff, 16'hc000, 16'hffff};
  logic [7:0] d;
  // ----------------------------------------------------------------------
  // Design, core model and clock
  // ----------------------------------------------------------------------
  fbo_ctrl fbo_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr),
    .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_wide_i(sfr_wide), .sfr_wdata_i(sfr_wdata),
    .sfr_rdata_o(sfr_rdata), .program_store_strobe_n_i(strobe_n), .addr_latch_i(latch),
    .external_access_select_i(ext_sel), .vpp_tied_logic_i(vpp_tied), .flash_status_i(status),
    .fetch_req_i(fetch_req), .fetch_addr_i(fetch_addr), .fetch_o(fetch),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .flash_req_o(freq),
    .boot_rom_enable_o(boot_en), .boot_vector_sel_o(vec_sel));
  fbo_core_model fbo_core_model_inst (.clk_i(clk_i), .sfr_addr_o(sfr_addr),
    .sfr_wr_o(sfr_wr), .sfr_rd_o(sfr_rd), .sfr_wide_o(sfr_wide), .sfr_wdata_o(sfr_wdata),
    .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr), .cmd_valid_o(cmd_valid),
    .cmd_o(cmd));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic end_sim();
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Takes the oldest note off the queue whenever a result shows
  initial forever begin
    logic rd, fe, cv;
    @(posedge clk_i);
    {rd, fe, cv} = {sfr_rd, fetch_req, cmd_valid};
    #2;
    if (rd) chk({16'h0, sfr_rdata}, exp_q.pop_front());
    if (fe) chk({10'h0, fetch}, exp_q.pop_front());
    if (cv) chk({2'b00, freq}, exp_q.pop_front());
  end
  // Cuts a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------------
  // Helpers for stimulus and expectations
  // ----------------------------------------------------------------------
  task automatic do_reset(input logic [7:0] st, input logic sn, input logic al,
                          input logic expv);
    {status, strobe_n, latch, ext_sel} = {st, sn, al, 1'b1};
    rst_n_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #2 rst_n_i = 1'b1;
    @(posedge clk_i); #2;
    chk({31'h0, boot_en}, {31'h0, expv});
    chk({31'h0, vec_sel}, {31'h0, expv});
  endtask
  task automatic rd_exp(input logic [10:0] a, input logic [15:0] v);
    exp_q.push_back({16'h0, v});
    fbo_core_model_inst.sfr_acc(1'b0, 1'b1, a, 16'h0);
  endtask
  task automatic fe_exp(input logic [19:0] a, input fbo_target_e t);
    exp_q.push_back({10'h0, t, a});
    fbo_core_model_inst.fetch(a);
  endtask
  function automatic logic [2:0] blk(input logic [15:0] a);
    return a < 16'h2000 ? 3'd0 : a < 16'h4000 ? 3'd1 : a < 16'h8000 ? 3'd2 :
           a < 16'hc000 ? 3'd3 : 3'd4;
  endfunction
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    {rst_n_i, strobe_n, latch, ext_sel, status} = {1'b0, 1'b1, 1'b0, 1'b1, 8'h00};
    vpp_tied = 1'b1;
    do_reset(8'h00, 1'b1, 1'b1, 1'b0);
    rd_exp(AUX_SFR_ADDR, 16'h0000);
    rd_exp(11'h4a9, 16'h0000);
    fe_exp(20'h0f900, FBO_TGT_FLASH);
    fe_exp(20'h10000, FBO_TGT_EXT);
    ext_sel = 1'b0;
    repeat (3) @(posedge clk_i);
    fe_exp(20'h0f900, FBO_TGT_EXT);
    ext_sel = 1'b1;
    repeat (3) @(posedge clk_i);
    fbo_core_model_inst.sfr_acc(1'b1, 1'b1, AUX_SFR_ADDR, 16'hffc0);
    rd_exp(AUX_SFR_ADDR, 16'h0080);
    repeat (115) @(posedge clk_i);
    rd_exp(AUX_SFR_ADDR, 16'h0080);
    repeat (10) @(posedge clk_i);
    rd_exp(AUX_SFR_ADDR, 16'h00c0);
    fe_exp(20'h0f800, FBO_TGT_BOOT);
    fe_exp(20'h0f7ff, FBO_TGT_FLASH);
    fe_exp(20'h0ffff, FBO_TGT_BOOT);
    for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed));
      exp_q.push_back({2'b00, 1'b1, fbo_op_e'(i % 4), blk(addrs[i]), addrs[i], d});
      fbo_core_model_inst.cmd(fbo_op_e'(i % 4), addrs[i], d);
    end
    fbo_core_model_inst.sfr_acc(1'b1, 1'b0, AUX_SFR_ADDR, 16'h0000);
    repeat (2) @(posedge clk_i);
    rd_exp(AUX_SFR_ADDR, 16'h0000);
    fe_exp(20'h0f800, FBO_TGT_FLASH);
    // External programming supply: valid follows boot enable at once
    vpp_tied = 1'b0;
    repeat (3) @(posedge clk_i);
    fbo_core_model_inst.sfr_acc(1'b1, 1'b0, AUX_SFR_ADDR, 16'h0080);
    rd_exp(AUX_SFR_ADDR, 16'h00c0);
    vpp_tied = 1'b1;
    do_reset(8'($random(seed)) | 8'h01, 1'b1, 1'b0, 1'b1);
    rd_exp(AUX_SFR_ADDR, 16'h0080);
    do_reset(8'h00, 1'b0, 1'b1, 1'b1);
    do_reset(8'h00, 1'b0, 1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    chk(exp_q.size(), 0);
    end_sim();
  end
endmodule // flash_boot_overlay_control_bench
